// [wdl_pkg.sv]
// package: constants, register map and control fields of the watchdog timer
package wdl_pkg;
  // register bus
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 32;
  localparam logic [7:0]  OFS_RELOAD      = 8'h00;
  localparam logic [7:0]  OFS_COUNT       = 8'h04;
  localparam logic [7:0]  OFS_SERVICE     = 8'h08;
  localparam logic [7:0]  OFS_CONTROL     = 8'h0C;
  localparam logic [7:0]  OFS_SERVICE_ALT = 8'h10;

  // control register fields
  localparam int          CON_IRQOPT_BIT  = 1;
  localparam int          CON_PRESC_LSB   = 2;
  localparam int          CON_PRESC_W     = 2;
  localparam int          CON_SECURE_BIT  = 4;
  localparam int          CON_WDEN_BIT    = 5;
  localparam int          CON_PERIOD_BIT  = 6;
  localparam int          CON_EN_BIT      = 7;
  localparam int          CON_UP_BIT      = 8;
  localparam int          CON_W           = 9;
  localparam logic [8:0]  CON_WMASK       = 9'h1FE;

  // reset values
  localparam logic [8:0]  CON_RESET       = 9'h000;
  localparam logic [15:0] RELOAD_RESET    = 16'h0000;
  localparam logic [15:0] COUNT_RESET     = 16'h0000;
  localparam logic [7:0]  LFSR_RESET      = 8'h00;
  localparam logic [7:0]  PRE_RESET       = 8'h00;

  // prescale codes and divide terminal counts
  localparam logic [1:0]  PRESC_DIV1      = 2'h0;
  localparam logic [1:0]  PRESC_DIV16     = 2'h1;
  localparam logic [1:0]  PRESC_DIV256    = 2'h2;
  localparam logic [1:0]  PRESC_ALT1      = 2'h3;
  localparam logic [7:0]  DIV16_LAST      = 8'h0F;
  localparam logic [7:0]  DIV256_LAST     = 8'hFF;

  // lfsr x8+x6+x5+x+1, galois form shifting toward the msb
  localparam logic [7:0]  LFSR_TAPS       = 8'h63;

  // timing
  localparam int          CLK_HZ          = 50_000_000;
  localparam int          CLK_PERIOD_NS   = 20;
  localparam int          SRC_HZ          = 32_768;
  localparam int          WD_MAX_TIMEOUT_S = 512;
  localparam longint      WD_MAX_SRC_TICKS =
    longint'(WD_MAX_TIMEOUT_S) * longint'(SRC_HZ);
  localparam longint      WD_MAX_CLK_CYCLES =
    longint'(WD_MAX_TIMEOUT_S) * longint'(CLK_HZ);
endpackage : wdl_pkg

// [wdl_watchdog.sv]
// watchdog timer with lfsr-checked servicing, one clock domain
//
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/10ps

//
// Contract
// - control bit 5 enters watchdog mode
// - watchdog counts down from reload value
// - expiry gives reset or interrupt per bit 1
// - service write reloads counter in watchdog mode
// - reload and control writes ignored in watchdog
// - only reset leaves watchdog mode
// - normal mode service write clears interrupt
// - prescale codes: 1, 16, 256, 11 as 00
// - watchdog counts the prescaled 32 kHz source
// - full scale at /256 reaches 512 s
// - secure value from 8-bit lfsr polynomial
// - matching secure write reloads, steps lfsr
// - mismatching secure write resets at once
// - zero seed always forces reset
// - lfsr state is never readable
// - watchdog enable resets cleared, normal mode
// - secure bit resets cleared, any-value service
// - irq option chooses interrupt over reset
// - direction, enable, mode bits with defaults; direction bit 8 is stored but ignored, counting is always down
// - normal mode counts prescaled 32 kHz source
// - enable gates counting, mode picks periodic
module wdl_watchdog #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input  wire logic                      clk_in,
  input  wire logic                      resetn_in,
  // 32 kHz source, one-cycle tick per source period
  input  wire logic                      src_tick_in,
  // register port
  input  wire logic [wdl_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [wdl_pkg::DATA_W-1:0] wdata_in,
  input  wire logic                      wr_in,
  input  wire logic                      rd_in,
  output logic      [wdl_pkg::DATA_W-1:0] rdata_out,
  // events
  output logic                           irq_out,
  output logic                           wd_reset_out,
  output logic                           wd_active_out
);

  typedef struct packed {
    logic [CNT_W-1:0]           reload;
    logic [CNT_W-1:0]           count;
    logic [wdl_pkg::CON_W-1:0]  con;
    logic [7:0]                 pre;
    logic [7:0]                 lfsr;
    logic                       irq;
    logic                       rst;
    logic [wdl_pkg::DATA_W-1:0] rdata;
  } wdl_state_t;

  wdl_state_t st_q;
  wdl_state_t st_d;

  function automatic logic wdl_hit(input logic [wdl_pkg::ADDR_W-1:0] a,
                                   input logic [7:0] ofs);
    wdl_hit = (a == ofs);
  endfunction : wdl_hit

  function automatic logic [7:0] wdl_lfsr_next(input logic [7:0] s);
    wdl_lfsr_next = {s[6:0], 1'b0} ^ (s[7] ? wdl_pkg::LFSR_TAPS : 8'h00);
  endfunction : wdl_lfsr_next

  // decoded accesses
  logic             wr_reload;
  logic             wr_count_ro;
  logic             wr_service;
  logic             wr_control;
  logic             wd_on;
  logic             secure_on;
  logic             irq_opt;
  logic [1:0]       presc;
  logic             div_tick;
  logic             run;
  logic             at_zero;
  logic             expire;
  logic             svc_match;
  logic             svc_ok;
  logic             svc_bad;
  logic             zero_seed;

  assign wr_reload   = wr_in && wdl_hit(addr_in, wdl_pkg::OFS_RELOAD);
  assign wr_count_ro = wr_in && wdl_hit(addr_in, wdl_pkg::OFS_COUNT);
  assign wr_service  = wr_in && (wdl_hit(addr_in, wdl_pkg::OFS_SERVICE) ||
                       wdl_hit(addr_in, wdl_pkg::OFS_SERVICE_ALT));
  assign wr_control  = wr_in && wdl_hit(addr_in, wdl_pkg::OFS_CONTROL);
  assign wd_on       = st_q.con[wdl_pkg::CON_WDEN_BIT];
  assign secure_on   = st_q.con[wdl_pkg::CON_SECURE_BIT];
  assign irq_opt     = st_q.con[wdl_pkg::CON_IRQOPT_BIT];
  assign presc       = st_q.con[wdl_pkg::CON_PRESC_LSB +: 2];

  // prescaler terminal: 11 behaves as 00
  // one shared prescaler keeps every ratio in phase with the source
  always_comb begin
    unique case (presc)
      wdl_pkg::PRESC_DIV16:  div_tick = src_tick_in &&
        ({4'h0, st_q.pre[3:0]} == wdl_pkg::DIV16_LAST);
      wdl_pkg::PRESC_DIV256: div_tick = src_tick_in &&
        (st_q.pre == wdl_pkg::DIV256_LAST);
      wdl_pkg::PRESC_DIV1,
      wdl_pkg::PRESC_ALT1:   div_tick = src_tick_in;
    endcase
  end

  // watchdog runs unconditionally, normal mode only when enabled
  assign run       = wd_on || st_q.con[wdl_pkg::CON_EN_BIT];
  assign at_zero   = (st_q.count == '0);
  assign expire    = run && div_tick && at_zero;
  assign svc_match = (wdata_in[7:0] == st_q.lfsr);
  assign svc_ok    = wd_on && wr_service && (!secure_on || svc_match);
  assign svc_bad   = wd_on && wr_service && secure_on && !svc_match;
  // a zero seed never leaves zero, so no write can service it
  assign zero_seed = wd_on && secure_on && (st_q.lfsr == 8'h00);

  always_comb begin
    st_d = st_q;
    st_d.rdata = '0;

    // prescaler counts every source tick
    if (src_tick_in) begin
      st_d.pre = st_q.pre + 8'h01;
    end

    // counter
    if (run && div_tick) begin
      if (!at_zero) begin
        st_d.count = st_q.count - 1'b1;
      end else if (wd_on) begin
        st_d.count = st_q.reload;
      end else if (st_q.con[wdl_pkg::CON_PERIOD_BIT]) begin
        st_d.count = st_q.reload;
      end else begin
        st_d.count = '1;
      end
    end

    // expiry: reset or interrupt
    if (expire) begin
      if (wd_on && !irq_opt) begin
        st_d.rst = 1'b1;
      end
    end

    // normal mode register writes; protected once watchdog is on
    if (!wd_on) begin
      if (wr_reload) begin
        st_d.reload = wdata_in[CNT_W-1:0];
        st_d.count  = wdata_in[CNT_W-1:0];
      end
      if (wr_control) begin
        st_d.con = wdata_in[wdl_pkg::CON_W-1:0] & wdl_pkg::CON_WMASK;
        st_d.pre = wdl_pkg::PRE_RESET;
        if (wdata_in[wdl_pkg::CON_WDEN_BIT]) begin
          st_d.count = st_q.reload;
        end
      end
      if (wr_service) begin
        st_d.irq  = 1'b0;
        st_d.lfsr = wdata_in[7:0];
      end
    end

    // service in the expiry cycle reloads; the expiry event still stands
    // watchdog servicing
    if (svc_ok) begin
      st_d.count = st_q.reload;
      st_d.irq   = 1'b0;
      if (secure_on) begin
        st_d.lfsr = wdl_lfsr_next(st_q.lfsr);
      end
    end
    if (svc_bad || zero_seed) begin
      st_d.rst = 1'b1;
    end

    // interrupt set wins over a clear in the same cycle
    if (expire && (!wd_on || irq_opt)) begin
      st_d.irq = 1'b1;
    end

    // read data, lfsr deliberately absent
    if (rd_in) begin
      if (wdl_hit(addr_in, wdl_pkg::OFS_RELOAD)) begin
        st_d.rdata[CNT_W-1:0] = st_q.reload;
      end else if (wdl_hit(addr_in, wdl_pkg::OFS_COUNT)) begin
        st_d.rdata[CNT_W-1:0] = st_q.count;
      end else if (wdl_hit(addr_in, wdl_pkg::OFS_CONTROL)) begin
        st_d.rdata[wdl_pkg::CON_W-1:0] = st_q.con;
      end
    end
  end

  // only reset clears watchdog mode and the reset request
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_q.reload <= wdl_pkg::RELOAD_RESET;
      st_q.count  <= wdl_pkg::COUNT_RESET;
      st_q.con    <= wdl_pkg::CON_RESET;
      st_q.pre    <= wdl_pkg::PRE_RESET;
      st_q.lfsr   <= wdl_pkg::LFSR_RESET;
      st_q.irq    <= 1'b0;
      st_q.rst    <= 1'b0;
      st_q.rdata  <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata_out     = st_q.rdata;
  assign irq_out       = st_q.irq;
  assign wd_reset_out  = st_q.rst;
  assign wd_active_out = st_q.con[wdl_pkg::CON_WDEN_BIT];

  // checks
  sequence seq_enter_wd;
    !wd_on && wr_control && wdata_in[wdl_pkg::CON_WDEN_BIT];
  endsequence

  sequence seq_secure_service;
    wd_on && secure_on && wr_service;
  endsequence

  sequence seq_normal_expiry;
    !wd_on && run && div_tick && at_zero && !wr_in;
  endsequence

  wd_enter_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    seq_enter_wd |=> wd_on && (st_q.count == $past(st_q.reload)))
    else $error("watchdog mode not entered with reload");

  wd_sticky_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    wd_on |=> wd_on)
    else $error("watchdog mode left without reset");

  reload_guard_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    wd_on && (wr_reload || wr_control)
      |=> $stable(st_q.reload) && $stable(st_q.con))
    else $error("protected register changed in watchdog mode");

  expiry_reset_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    wd_on && !irq_opt && div_tick && at_zero |=> wd_reset_out [*3])
    else $error("expiry did not hold reset request");

  expiry_irq_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    wd_on && irq_opt && div_tick && at_zero && !svc_bad && !zero_seed
      && !wd_reset_out |=> irq_out && !wd_reset_out)
    else $error("irq option expiry wrong");

  plain_service_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    wd_on && !secure_on && wr_service |=> st_q.count == st_q.reload)
    else $error("service write did not reload counter");

  secure_step_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    seq_secure_service ##0 svc_match && !expire && !wd_reset_out
      && (st_q.lfsr != 8'h00)
      |=> st_q.lfsr == wdl_lfsr_next($past(st_q.lfsr)) && !wd_reset_out)
    else $error("lfsr did not advance on matching service");

  secure_bad_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    seq_secure_service ##0 !svc_match |=> wd_reset_out)
    else $error("mismatching service did not reset");

  zero_seed_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    wd_on && secure_on && st_q.lfsr == 8'h00 |=> wd_reset_out)
    else $error("zero seed did not force reset");

  normal_clear_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    !wd_on && wr_service && !expire |=> !irq_out)
    else $error("normal mode clear left interrupt set");

  count_step_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    wd_on && div_tick && !at_zero && !wr_service
      |=> st_q.count == $past(st_q.count) - 1'b1)
    else $error("watchdog count did not step down");

  div1_alias_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    run && src_tick_in && (presc == wdl_pkg::PRESC_ALT1) && !at_zero
      && !wr_in |=> st_q.count == $past(st_q.count) - 1'b1)
    else $error("prescale 11 not divide by one");

  // reset-hold, counting, prescaler, interrupt and read-side checks
  reset_hold_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    wd_reset_out |=> wd_reset_out)
    else $error("reset request dropped without reset");

  count_readonly_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    wr_count_ro && !(run && div_tick) |=> $stable(st_q.count))
    else $error("write to count register took effect");

  normal_idle_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    !wd_on && !st_q.con[wdl_pkg::CON_EN_BIT] && !wr_reload && !wr_control
      |=> $stable(st_q.count))
    else $error("disabled timer counted");

  source_gate_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    wd_on && !src_tick_in && !wr_service |=> $stable(st_q.count))
    else $error("watchdog counted without source tick");

  periodic_reload_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    seq_normal_expiry ##0 st_q.con[wdl_pkg::CON_PERIOD_BIT]
      |=> st_q.count == $past(st_q.reload))
    else $error("periodic timer did not reload");

  freerun_wrap_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    seq_normal_expiry ##0 !st_q.con[wdl_pkg::CON_PERIOD_BIT]
      |=> &st_q.count)
    else $error("free-running timer did not wrap");

  normal_irq_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    seq_normal_expiry |=> irq_out)
    else $error("normal expiry did not raise interrupt");

  wd_reload_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    wd_on && div_tick && at_zero |=> st_q.count == st_q.reload)
    else $error("watchdog did not reload on expiry");

  service_hidden_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    rd_in && (wdl_hit(addr_in, wdl_pkg::OFS_SERVICE) ||
              wdl_hit(addr_in, wdl_pkg::OFS_SERVICE_ALT))
      |=> rdata_out == '0)
    else $error("service register read back a value");

  div16_hold_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    run && src_tick_in && (presc == wdl_pkg::PRESC_DIV16) && !wr_in
      && ({4'h0, st_q.pre[3:0]} != wdl_pkg::DIV16_LAST)
      |=> $stable(st_q.count))
    else $error("divide by 16 stepped early");

  div256_hold_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    run && src_tick_in && (presc == wdl_pkg::PRESC_DIV256) && !wr_in
      && (st_q.pre != wdl_pkg::DIV256_LAST)
      |=> $stable(st_q.count))
    else $error("divide by 256 stepped early");

  plain_no_reset_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    wd_on && !secure_on && wr_service && !div_tick && !wd_reset_out
      |=> !wd_reset_out)
    else $error("plain service caused a reset");

  pre_step_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    src_tick_in && !wr_control |=> st_q.pre == $past(st_q.pre) + 8'h01)
    else $error("prescaler did not advance");
endmodule : wdl_watchdog

// [wdl_testbench.sv]
// self-checking random testbench of the watchdog timer
`timescale 1ns/10ps
module testbench;
  logic        clk_in;
  logic        resetn_in;
  logic        src_tick_in;
  logic [7:0]  addr_in;
  logic [31:0] wdata_in;
  logic        wr_in;
  logic        rd_in;
  logic [31:0] rdata_out;
  logic        irq_out;
  logic        wd_reset_out;
  logic        wd_active_out;
  int          err_count;
  int          checks_done;
  logic [31:0] rv;
  logic [7:0]  s;
  logic [15:0] ld;
  int          dv;

  wdl_watchdog u_wdl_watchdog (
    .clk_in(clk_in), .resetn_in(resetn_in), .src_tick_in(src_tick_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .irq_out(irq_out), .wd_reset_out(wd_reset_out),
    .wd_active_out(wd_active_out));

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  // galois step of x8+x6+x5+x+1, shifting toward the msb
  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return v[7] ? ({v[6:0], 1'b0} ^ 8'h63) : {v[6:0], 1'b0};
  endfunction : lfsr_next

  task automatic finish_test;
    $display("mismatches %0d, comparisons %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test

  task automatic check(input logic [31:0] got, exp, input string m);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : check

  task automatic do_reset;
    resetn_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    resetn_in <= 1'b1;
    @(posedge clk_in);
  endtask : do_reset

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clk_in);
    wr_in    <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_in);
    rd_in   <= 1'b0;
    #1 rv = rdata_out;
  endtask : rd

  // one source tick per clock for n clocks, then idle
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk_in);
      src_tick_in <= 1'b1;
    end
    @(posedge clk_in);
    src_tick_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
  endtask : tick

  initial begin
    #1ms;
    err_count++;
    finish_test();
  end

  initial begin
    resetn_in   = 1'b0;
    src_tick_in = 1'b0;
    addr_in     = 8'h00;
    wdata_in    = 32'h0;
    wr_in       = 1'b0;
    rd_in       = 1'b0;
    err_count   = 0;
    checks_done = 0;
    void'($urandom(32'h13280F9D));
    do_reset();
    rd(8'h0C);
    check(rv, 32'h0, "control reset");
    rd(8'h00);
    check(rv, 32'h0, "reload reset");
    rd(8'h08);
    check(rv, 32'h0, "service read");
    rd(8'h14);
    check(rv, 32'h0, "unmapped read");
    // prescale codes, sampled mid-period so edge phase does not matter
    for (int c = 0; c < 4; c++) begin
      dv = (c == 1) ? 16 : (c == 2) ? 256 : 1;
      ld = 16'($urandom_range(16'hFFFF, 16'h0100));
      wr(8'h00, {16'h0, ld});
      wr(8'h0C, 32'h80 | (c << 2));
      tick(dv * 3 + dv / 2);
      rd(8'h04);
      check(rv, {16'h0, ld - 16'h3}, "prescale");
    end
    // disabled timer holds its count
    wr(8'h0C, 32'h0);
    tick(3);
    rd(8'h04);
    check(rv, {16'h0, ld - 16'h3}, "disabled hold");
    wr(8'h00, 32'h3);
    wr(8'h0C, 32'hC0);
    tick(4);
    check(irq_out, 1'b1, "periodic irq");
    rd(8'h04);
    check(rv, 32'h3, "periodic reload");
    wr(8'h08, 32'h5A);
    @(posedge clk_in);
    #1;
    check(irq_out, 1'b0, "irq clear");
    wr(8'h00, 32'h2);
    wr(8'h0C, 32'h80);
    tick(3);
    rd(8'h04);
    check(rv, 32'hFFFF, "free-run wrap");
    check(irq_out, 1'b1, "free-run irq");
    // plain watchdog, reset on expiry
    do_reset();
    wr(8'h00, 32'h5);
    wr(8'h0C, 32'h20);
    check(wd_active_out, 1'b1, "wd active");
    wr(8'h0C, 32'h0);
    wr(8'h00, 32'h9);
    wr(8'h04, 32'h1);
    rd(8'h0C);
    check(rv, 32'h20, "control locked");
    rd(8'h00);
    check(rv, 32'h5, "reload locked");
    rd(8'h04);
    check(rv, 32'h5, "count read only");
    tick(3);
    wr(8'h10, 32'h0);
    rd(8'h04);
    check(rv, 32'h5, "service reload");
    tick(5);
    check(wd_reset_out, 1'b0, "no early reset");
    tick(1);
    check(wd_reset_out, 1'b1, "expiry reset");
    check(irq_out, 1'b0, "no irq on reset");
    do_reset();
    check(wd_active_out, 1'b0, "wd left");
    // interrupt option
    wr(8'h00, 32'h2);
    wr(8'h0C, 32'h22);
    tick(3);
    check(irq_out, 1'b1, "wd irq");
    check(wd_reset_out, 1'b0, "wd irq no reset");
    // secure servicing, documented seed first, then random seeds
    for (int it = 0; it < 4; it++) begin
      do_reset();
      s = (it == 0) ? 8'hAA : 8'($urandom_range(255, 1));
      wr(8'h08, {24'h0, s});
      wr(8'h00, 32'h64);
      wr(8'h0C, 32'h30);
      repeat (3) begin
        wr(8'h08, {24'h0, s});
        s = lfsr_next(s);
      end
      check(wd_reset_out, 1'b0, "secure match");
      rd(8'h04);
      check(rv, 32'h64, "secure reload");
      wr(8'h08, {24'h0, (it == 0) ? 8'h66 : s ^ 8'($urandom_range(255, 1))});
      @(posedge clk_in);
      #1;
      check(wd_reset_out, 1'b1, "secure mismatch");
    end
    do_reset();
    wr(8'h08, 32'h0);
    wr(8'h0C, 32'h30);
    wr(8'h08, 32'h0);
    @(posedge clk_in);
    #1;
    check(wd_reset_out, 1'b1, "zero seed");
    finish_test();
  end
endmodule : testbench
